// ### rtl/plt_port_timing.sv
`timescale 1ns/100ps

// Summary of operation
// - Idle 10 Mb/s sends one-cycle pulse every 16 ms
// - FLP clock pulses 125 us apart, 100 ns
// - Data pulse 62 us after clock for one
// - Burst spans 2 ms, bursts repeat each 16 ms
// - Signal detect rises within 1 ms; held low at 10 Mb/s
// - Signal detect falls within 350 us
// - Loopback entry at 100 Mb/s blanks receive
// - 100 Mb/s loopback valid within 240 ns
// - 10 Mb/s loopback valid within 2 us
// - Reference clock times all RMII transfers
// - Transmit bits and enable sampled rising edge
// - Transmit data reaches line after 11 bits
// - Receive outputs change after rising edge
// - Carrier valid rises 18.5 bits after start
// - Carrier valid drops 27 bits after end
// - Asynchronous rise, toggles at packet end
// - Extra synchronous receive data valid output
// - Receive data appears 38 bits after pair
// - Elasticity setting defaults to 01
// - Isolate clear resumes operation within 100 us
// - MAC clock out toggles every core clock cycle, in either mode

module plt_port_timing #(
  parameter int unsigned P_NLP_PERIOD_CYC = plt_pkg::NLP_PERIOD_CYC,
  parameter int unsigned P_FLP_PERIOD_CYC = plt_pkg::FLP_PERIOD_CYC,
  parameter int unsigned P_FLP_BURST_CYC  = plt_pkg::FLP_BURST_CYC,
  parameter int unsigned P_SD_ON_CYC      = plt_pkg::SD_ON_CYC,
  parameter int unsigned P_LB_DEAD_CYC    = plt_pkg::LB_DEAD_CYC
) (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_nrst,
  input  wire logic                     i_speed_100,
  input  wire logic                     i_autoneg_en,
  input  wire logic [plt_pkg::FLP_SLOTS-1:0] i_flp_word,
  input  wire logic                     i_rmii_mode,
  input  wire logic                     i_loopback,
  input  wire logic                     i_isolate_ctl,
  input  wire logic                     i_elastic_wr,
  input  wire logic [1:0]               i_elastic_cfg,
  input  wire logic                     i_rx_energy,
  input  wire logic                     i_rx_sos,
  input  wire logic                     i_rx_eos,
  input  wire logic                     i_rx_dv_line,
  input  wire logic [1:0]               i_rxd_line,
  input  wire logic                     i_rx_er_line,
  input  wire logic                     i_tx_en,
  input  wire logic [1:0]               i_txd,
  output logic                          o_link_pulse,
  output logic                          o_signal_detect,
  output logic                          o_line_tx_en,
  output logic [1:0]                    o_line_txd,
  output logic                          o_crs_dv,
  output logic                          o_rx_dv,
  output logic [1:0]                    o_rxd,
  output logic                          o_rx_er,
  output logic                          o_isolated,
  output logic                          o_mac_clock_out,
  output logic [1:0]                    o_elastic_sel
);
  import plt_pkg::*;

  // Delay depths; receive paths lose one stage to the output flops
  localparam int unsigned RX_DEPTH    = RX_LAT_CYC - 1;
  localparam int unsigned LB100_DEPTH = LB100_CYC - 1;
  localparam int unsigned LB10_DEPTH  = LB10_CYC - 1;
  localparam int unsigned OFF_DEPTH   = CRS_OFF_CYC - 1;
  localparam int unsigned LP_WIDTH    = FLP_PULSE_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic       energy_m_q;
  logic       energy_s_q;
  plt_cnt_t   sd_cnt_q;
  plt_cnt_t   sd_cnt_d;
  logic       sd_q;
  logic       sd_d;
  plt_cnt_t   prd_q;
  plt_cnt_t   prd_d;
  plt_cnt_t   slot_cnt_q;
  plt_cnt_t   slot_cnt_d;
  logic [4:0] slot_idx_q;
  logic [4:0] slot_idx_d;
  plt_cnt_t   pw_q;
  plt_cnt_t   pw_d;
  logic       pulse_q;
  plt_cnt_t   iso_cnt_q;
  logic       iso_q;
  logic       lb_q;
  plt_cnt_t   dead_cnt_q;
  logic       crs_q;
  logic       tgl_q;
  logic [3:0] rx_q;
  plt_cnt_t   mco_cnt_q;
  logic       mco_q;
  logic [1:0] elastic_q;

  ////////////////////////////////////////////////////////////////////////////
  // Energy pin synchroniser
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      energy_m_q <= 1'b0;
      energy_s_q <= 1'b0;
    end else begin
      energy_m_q <= i_rx_energy;
      energy_s_q <= energy_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Signal detect filter, 100 Mb/s only; limit leaves room for the sync
  wire      sd_mismatch = i_speed_100 & (energy_s_q ^ sd_q);
  plt_cnt_t sd_lim;

  assign sd_lim = sd_q ? plt_cnt_t'(SD_OFF_CYC - SYNC_STAGES - 1)
                       : plt_cnt_t'(P_SD_ON_CYC - SYNC_STAGES - 1);
  assign sd_d   = !i_speed_100 ? 1'b0
                : (sd_mismatch && sd_cnt_q >= sd_lim) ? energy_s_q
                : sd_q;
  assign sd_cnt_d = (!sd_mismatch || sd_d != sd_q) ? '0 : sd_cnt_q + 1'b1;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sd_q     <= 1'b0;
      sd_cnt_q <= '0;
    end else begin
      sd_q     <= sd_d;
      sd_cnt_q <= sd_cnt_d;
    end
  end

  assign o_signal_detect = sd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Link pulse sequencer: one period counter for NLP and FLP
  wire      nlp_en  = !i_speed_100 && !i_autoneg_en && !i_tx_en;
  wire      lp_en   = nlp_en || i_autoneg_en;
  wire      prd_end = (prd_q == (i_autoneg_en ? plt_cnt_t'(P_FLP_PERIOD_CYC - 1)
                                              : plt_cnt_t'(P_NLP_PERIOD_CYC - 1)));
  wire      slot_end = (slot_cnt_q == plt_cnt_t'(FLP_CLK_CYC - 1));
  wire      in_burst = (prd_q <= plt_cnt_t'(P_FLP_BURST_CYC));
  wire      flp_clk  = i_autoneg_en && in_burst && slot_cnt_q == '0
                       && slot_idx_q <= 5'(FLP_SLOTS);
  wire      flp_dat  = i_autoneg_en && in_burst && slot_idx_q < 5'(FLP_SLOTS)
                       && slot_cnt_q == plt_cnt_t'(FLP_DATA_CYC)
                       && i_flp_word[slot_idx_q[3:0]];
  wire      nlp_trig = nlp_en && prd_q == '0;
  wire      lp_trig  = nlp_trig || flp_clk || flp_dat;

  assign prd_d      = (!lp_en || prd_end) ? '0 : prd_q + 1'b1;
  assign slot_cnt_d = (!lp_en || prd_end || slot_end) ? '0 : slot_cnt_q + 1'b1;
  assign slot_idx_d = (!lp_en || prd_end) ? 5'h0
                    : (slot_end && slot_idx_q <= 5'(FLP_SLOTS)) ? slot_idx_q + 5'h1
                    : slot_idx_q;
  assign pw_d       = lp_trig ? plt_cnt_t'(LP_WIDTH - 1)
                    : (pw_q != '0) ? pw_q - 1'b1 : '0;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prd_q      <= '0;
      slot_cnt_q <= '0;
      slot_idx_q <= 5'h0;
      pw_q       <= '0;
      pulse_q    <= 1'b0;
    end else begin
      prd_q      <= prd_d;
      slot_cnt_q <= slot_cnt_d;
      slot_idx_q <= slot_idx_d;
      pw_q       <= pw_d;
      pulse_q    <= lp_trig || pw_q != '0;
    end
  end

  assign o_link_pulse = pulse_q;

  ////////////////////////////////////////////////////////////////////////////
  // Isolate exit timer
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      iso_q     <= 1'b0;
      iso_cnt_q <= '0;
    end else if (i_isolate_ctl) begin
      iso_q     <= 1'b1;
      iso_cnt_q <= '0;
    end else if (iso_q) begin
      iso_q     <= (iso_cnt_q != plt_cnt_t'(ISO_EXIT_CYC - 1));
      iso_cnt_q <= iso_cnt_q + 1'b1;
    end
  end

  assign o_isolated = iso_q;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path: MAC bits sampled on the rising edge, fixed line latency
  wire [2:0] tx_in = iso_q ? 3'h0 : {i_tx_en, i_txd};
  wire [2:0] tx_line;

  plt_delay #(.WIDTH(3), .DEPTH(TX_LAT_CYC)) u_tx_dly (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_data     (tx_in),
    .o_data     (tx_line)
  );

  assign o_line_tx_en = tx_line[2];
  assign o_line_txd   = tx_line[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Receive, loopback and carrier delay lines
  wire [3:0] rx_line;
  wire [2:0] lb100_out;
  wire [2:0] lb10_out;
  wire       crs_on_tap;
  wire       crs_off_tap;

  plt_delay #(.WIDTH(4), .DEPTH(RX_DEPTH)) u_rx_dly (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_data     ({i_rx_er_line, i_rx_dv_line, i_rxd_line}),
    .o_data     (rx_line)
  );

  plt_delay #(.WIDTH(3), .DEPTH(LB100_DEPTH)) u_lb100_dly (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_data     (tx_in),
    .o_data     (lb100_out)
  );

  plt_delay #(.WIDTH(3), .DEPTH(LB10_DEPTH)) u_lb10_dly (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_data     (tx_in),
    .o_data     (lb10_out)
  );

  plt_delay #(.WIDTH(1), .DEPTH(CRS_ON_CYC)) u_crs_on_dly (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_data     (i_rx_sos),
    .o_data     (crs_on_tap)
  );

  plt_delay #(.WIDTH(1), .DEPTH(OFF_DEPTH)) u_crs_off_dly (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_data     (i_rx_eos),
    .o_data     (crs_off_tap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Loopback dead time after entry at 100 Mb/s
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lb_q       <= 1'b0;
      dead_cnt_q <= '0;
    end else begin
      lb_q <= i_loopback;
      if (i_loopback && !lb_q && i_speed_100) begin
        dead_cnt_q <= plt_cnt_t'(P_LB_DEAD_CYC);
      end else if (dead_cnt_q != '0) begin
        dead_cnt_q <= dead_cnt_q - 1'b1;
      end
    end
  end

  // Receive source selection, blanked in isolate and dead time
  wire [2:0] lb_src = i_speed_100 ? lb100_out : lb10_out;
  wire [3:0] lb_rx  = (dead_cnt_q != '0) ? 4'h0 : {1'b0, lb_src};
  wire [3:0] rx_sel = iso_q ? 4'h0 : i_loopback ? lb_rx : rx_line;

  // Receive output flops and carrier state
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_q  <= 4'h0;
      crs_q <= 1'b0;
      tgl_q <= 1'b0;
    end else begin
      rx_q  <= rx_sel;
      crs_q <= crs_on_tap || (crs_q && !crs_off_tap);
      tgl_q <= !crs_q && rx_q[2] && !tgl_q;
    end
  end

  assign o_rx_er  = rx_q[3];
  assign o_rx_dv  = rx_q[2];
  assign o_rxd    = rx_q[1:0];
  // Rise straight from the tap, toggle while data drains after carrier
  assign o_crs_dv = !iso_q && (i_loopback ? rx_q[2]
                  : (crs_on_tap || crs_q || (rx_q[2] && tgl_q)));

  ////////////////////////////////////////////////////////////////////////////
  // MAC clock output, half period chosen by interface mode
  wire plt_cnt_t mco_half = i_rmii_mode ? plt_cnt_t'(MCO_RMII_CYC) : plt_cnt_t'(MCO_MII_CYC);
  wire           mco_flip = (mco_cnt_q >= mco_half - 1'b1);

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mco_cnt_q <= '0;
      mco_q     <= 1'b0;
    end else begin
      mco_cnt_q <= mco_flip ? '0 : mco_cnt_q + 1'b1;
      mco_q     <= mco_flip ? !mco_q : mco_q;
    end
  end

  assign o_mac_clock_out = mco_q;

  ////////////////////////////////////////////////////////////////////////////
  // Elasticity setting, defaults to 01 at reset
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      elastic_q <= ELASTIC_DFLT;
    end else if (i_elastic_wr) begin
      elastic_q <= i_elastic_cfg;
    end
  end

  assign o_elastic_sel = elastic_q;

endmodule

// ### rtl/plt_pkg.sv
package plt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and counter sizing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CNT_W         = 18;
  localparam int unsigned SYNC_STAGES   = 2;

  typedef logic [CNT_W-1:0] plt_cnt_t;

  ////////////////////////////////////////////////////////////////////////////
  // Times as specified, in their own units
  localparam int unsigned NLP_WIDTH_NS     = 100;
  localparam int unsigned NLP_PERIOD_MS    = 16;
  localparam int unsigned FLP_PULSE_NS     = 100;
  localparam int unsigned FLP_CLK_US       = 125;
  localparam int unsigned FLP_DATA_US      = 62;
  localparam int unsigned FLP_BURST_MS     = 2;
  localparam int unsigned FLP_PERIOD_MS    = 16;
  localparam int unsigned SD_ON_MS         = 1;
  localparam int unsigned SD_OFF_US        = 350;
  localparam int unsigned LB_DEAD_US       = 550;
  localparam int unsigned LB100_NS         = 240;
  localparam int unsigned LB10_US          = 2;
  localparam int unsigned ISO_EXIT_US      = 100;
  localparam int unsigned BIT100_NS        = 10;
  localparam int unsigned TX_LAT_BITS      = 11;
  localparam int unsigned CRS_ON_HALF_BITS = 37;
  localparam int unsigned CRS_OFF_BITS     = 27;
  localparam int unsigned RX_LAT_BITS      = 38;
  localparam int unsigned REFCLK_RMII_NS   = 20;
  localparam int unsigned MCO_MII_NS       = 20;
  localparam int unsigned MCO_RMII_NS      = 10;

  // Reset values
  localparam logic [1:0] ELASTIC_DFLT = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Rounding of a time in ns to cycles, never below one cycle
  function automatic int unsigned cyc_near(input longint unsigned t_ns);
    longint unsigned c;
    c = (t_ns + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : int'(c);
  endfunction

  function automatic int unsigned cyc_floor(input longint unsigned t_ns);
    longint unsigned c;
    c = t_ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : int'(c);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Derived cycle counts
  localparam int unsigned FLP_SLOTS      = (FLP_BURST_MS * 1000) / FLP_CLK_US;
  localparam int unsigned NLP_WIDTH_CYC  = cyc_near(NLP_WIDTH_NS);
  localparam int unsigned FLP_PULSE_CYC  = cyc_near(FLP_PULSE_NS);
  localparam int unsigned NLP_PERIOD_CYC = cyc_near(64'(NLP_PERIOD_MS) * 1000000);
  localparam int unsigned FLP_CLK_CYC    = cyc_near(64'(FLP_CLK_US) * 1000);
  localparam int unsigned FLP_DATA_CYC   = cyc_near(64'(FLP_DATA_US) * 1000);
  localparam int unsigned FLP_BURST_CYC  = cyc_near(64'(FLP_BURST_MS) * 1000000);
  localparam int unsigned FLP_PERIOD_CYC = cyc_near(64'(FLP_PERIOD_MS) * 1000000);
  localparam int unsigned SD_ON_CYC      = cyc_floor(64'(SD_ON_MS) * 1000000);
  localparam int unsigned SD_OFF_CYC     = cyc_floor(64'(SD_OFF_US) * 1000);
  localparam int unsigned LB_DEAD_CYC    = cyc_floor(64'(LB_DEAD_US) * 1000);
  localparam int unsigned LB100_CYC      = cyc_floor(LB100_NS);
  localparam int unsigned LB10_CYC       = cyc_floor(64'(LB10_US) * 1000);
  localparam int unsigned ISO_EXIT_CYC   = cyc_floor(64'(ISO_EXIT_US) * 1000);
  localparam int unsigned TX_LAT_CYC     = cyc_near(TX_LAT_BITS * BIT100_NS);
  localparam int unsigned CRS_ON_CYC     = cyc_near(CRS_ON_HALF_BITS * BIT100_NS / 2);
  localparam int unsigned CRS_OFF_CYC    = cyc_near(CRS_OFF_BITS * BIT100_NS);
  localparam int unsigned RX_LAT_CYC     = cyc_near(RX_LAT_BITS * BIT100_NS);
  localparam int unsigned MCO_MII_CYC    = cyc_near(MCO_MII_NS);
  localparam int unsigned MCO_RMII_CYC   = cyc_near(MCO_RMII_NS);

endpackage

// ### rtl/plt_delay.sv
`timescale 1ns/100ps

module plt_delay #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 1
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_data,
  output logic      [WIDTH-1:0] o_data
);
  import plt_pkg::*;

  logic [WIDTH-1:0] stage_q [DEPTH];

  // Fixed-latency shift line, input captured on every rising edge
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_q[i] <= '0;
      end
    end else begin
      stage_q[0] <= i_data;
      for (int i = 1; i < DEPTH; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign o_data = stage_q[DEPTH-1];

endmodule

// ### dv/plt_port_timing_assertions.sv
`timescale 1ns/100ps

module plt_port_timing_assertions #(
  parameter int unsigned P_LB_DEAD_CYC = 10
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_speed_100,
  input  wire logic       i_autoneg_en,
  input  wire logic       i_loopback,
  input  wire logic       i_isolate_ctl,
  input  wire logic       i_rx_sos,
  input  wire logic       i_rx_eos,
  input  wire logic       i_rx_dv_line,
  input  wire logic [1:0] i_rxd_line,
  input  wire logic       i_tx_en,
  input  wire logic [1:0] i_txd,
  input  wire logic       o_link_pulse,
  input  wire logic       o_line_tx_en,
  input  wire logic [1:0] o_line_txd,
  input  wire logic       o_crs_dv,
  input  wire logic       o_rx_dv,
  input  wire logic [1:0] o_rxd,
  input  wire logic       o_isolated,
  input  wire logic       o_mac_clock_out
);
  localparam int ISO_LIMIT = 1000;

  int quiet_q;
  int lb_q;
  int iso_wait_q;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  ////////////////////////////////////////////////////////////////////////
  // Cycles spent in plain receive, and in 100 Mb/s loopback
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      quiet_q    <= 0;
      lb_q       <= 0;
      iso_wait_q <= 0;
    end else begin
      // Cycles still isolated after the control bit was cleared
      iso_wait_q <= (i_isolate_ctl || !o_isolated) ? 0
                  : iso_wait_q + int'(iso_wait_q <= ISO_LIMIT);
      quiet_q <= (i_loopback || i_isolate_ctl || o_isolated) ? 0 : quiet_q + int'(quiet_q < 9);
      lb_q    <= (i_loopback && i_speed_100) ? lb_q + int'(lb_q < 99999) : 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stream start and end markers seen in plain receive
  sequence sos_seen;
    i_rx_sos && quiet_q > 8;
  endsequence
  sequence eos_alone;
    i_rx_eos && !i_rx_sos && quiet_q > 8 ##1 !i_rx_sos [*3];
  endsequence

  chk_crs_rise: assert property (sos_seen |-> ##3 o_crs_dv)
    else $error("carrier valid late after stream start");
  chk_crs_drop: assert property (eos_alone |-> !o_crs_dv)
    else $error("carrier valid still high after stream end");
  chk_rx_latency: assert property (quiet_q > 8 |->
    o_rxd == $past(i_rxd_line, 4) && o_rx_dv == $past(i_rx_dv_line, 4))
    else $error("receive outputs off their latency");
  chk_tx_latency: assert property ($past(i_nrst) && !o_isolated && !$past(o_isolated) |->
    o_line_txd == $past(i_txd) && o_line_tx_en == $past(i_tx_en))
    else $error("line transmit does not follow the MAC");
  chk_pulse_width: assert property (o_link_pulse |=> !o_link_pulse)
    else $error("link pulse wider than one cycle");
  chk_pulse_held: assert property (
    !$past(i_autoneg_en) && ($past(i_tx_en) || $past(i_speed_100)) |-> !o_link_pulse)
    else $error("idle pulse while sending or at 100 Mb/s");
  chk_mac_clock: assert property ($past(i_nrst) |-> o_mac_clock_out != $past(o_mac_clock_out))
    else $error("MAC clock output stopped");
  chk_iso_enter: assert property ($rose(i_isolate_ctl) |=> o_isolated)
    else $error("isolate not entered");
  chk_iso_leave: assert property (iso_wait_q <= ISO_LIMIT)
    else $error("isolate left too late");
  chk_lb_fast: assert property (
    $rose(i_tx_en) && i_speed_100 && lb_q > P_LB_DEAD_CYC + 4 |-> ##[1:3] o_rx_dv)
    else $error("loopback receive valid late");
endmodule

bind plt_port_timing plt_port_timing_assertions #(.P_LB_DEAD_CYC(P_LB_DEAD_CYC)) u_chk (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_speed_100(i_speed_100),
  .i_autoneg_en(i_autoneg_en), .i_loopback(i_loopback), .i_isolate_ctl(i_isolate_ctl),
  .i_rx_sos(i_rx_sos), .i_rx_eos(i_rx_eos), .i_rx_dv_line(i_rx_dv_line),
  .i_rxd_line(i_rxd_line), .i_tx_en(i_tx_en), .i_txd(i_txd), .o_link_pulse(o_link_pulse),
  .o_line_tx_en(o_line_tx_en), .o_line_txd(o_line_txd), .o_crs_dv(o_crs_dv),
  .o_rx_dv(o_rx_dv), .o_rxd(o_rxd), .o_isolated(o_isolated),
  .o_mac_clock_out(o_mac_clock_out)
);

// ### dv/plt_mac_model.sv
`timescale 1ns/100ps

module plt_mac_model (
  input  wire logic       i_core_clk,
  output logic            o_tx_en,
  output logic [1:0]      o_txd
);
  // Idle until a frame is asked for
  initial begin
    o_tx_en = 1'h0;
    o_txd   = 2'h0;
  end

  // Eight dibits, lsb first; idle data shows the inverse of the last dibit
  task automatic send(input logic [15:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge i_core_clk);
      o_tx_en = 1'h1;
      o_txd   = d[2*i +: 2];
    end
    @(negedge i_core_clk);
    o_tx_en = 1'h0;
    o_txd   = ~o_txd;
  endtask
endmodule

// ### dv/plt_port_timing_bench.sv
`timescale 1ns/100ps

module plt_port_timing_bench;
  import plt_pkg::*;

  localparam int NLP_CYC  = 40;
  localparam int FLP_PER  = 25000;
  localparam int SD_ON    = 20;
  localparam int LB_DEAD  = 10;
  localparam int CLK_GAP  = FLP_CLK_US * 1000 / CLK_PERIOD_NS;
  localparam int DATA_GAP = FLP_DATA_US * 1000 / CLK_PERIOD_NS;

  logic                 clk = 1'h0;
  logic                 nrst = 1'h0;
  logic                 speed = 1'h1;
  logic                 rmii = 1'h1;
  logic                 an = 1'h0;
  logic [FLP_SLOTS-1:0] flp = 16'h8005;
  logic                 lb = 1'h0, iso = 1'h0, ewr = 1'h0, energy = 1'h0;
  logic                 sos = 1'h0, eos = 1'h0, rdv = 1'h0, rer = 1'h0;
  logic [1:0]           ecfg = 2'h0, rxd = 2'h0;
  logic                 tx_en, lp, sd, ltx_en, crs, rx_dv, rx_er, isol, mclk;
  logic [1:0]           txd, ltxd, rxdo, esel;
  logic [2:0]           e;
  logic [3:0]           rows [8] = '{4'h9, 4'hB, 4'hD, 4'hF, 4'h8, 4'hA, 4'h1, 4'h0};
  int                   bad_count = 0;
  int                   tests_run = 0;
  int                   n, cnt;
  int                   got [$];
  int                   want [$];

  ////////////////////////////////////////////////////////////////////////
  // Core clock in place of the reference clock
  always #50 clk = ~clk;

  plt_port_timing #(
    .P_NLP_PERIOD_CYC(NLP_CYC), .P_FLP_PERIOD_CYC(FLP_PER),
    .P_SD_ON_CYC(SD_ON), .P_LB_DEAD_CYC(LB_DEAD)
  ) DUT (
    .i_core_clk(clk), .i_nrst(nrst), .i_speed_100(speed), .i_autoneg_en(an),
    .i_flp_word(flp), .i_rmii_mode(rmii), .i_loopback(lb), .i_isolate_ctl(iso),
    .i_elastic_wr(ewr), .i_elastic_cfg(ecfg), .i_rx_energy(energy), .i_rx_sos(sos),
    .i_rx_eos(eos), .i_rx_dv_line(rdv), .i_rxd_line(rxd), .i_rx_er_line(rer),
    .i_tx_en(tx_en), .i_txd(txd), .o_link_pulse(lp), .o_signal_detect(sd),
    .o_line_tx_en(ltx_en), .o_line_txd(ltxd), .o_crs_dv(crs), .o_rx_dv(rx_dv),
    .o_rxd(rxdo), .o_rx_er(rx_er), .o_isolated(isol), .o_mac_clock_out(mclk),
    .o_elastic_sel(esel)
  );

  plt_mac_model mac (.i_core_clk(clk), .o_tx_en(tx_en), .o_txd(txd));

  ////////////////////////////////////////////////////////////////////////
  // Comparisons, waits and the closing verdict
  task automatic chk_bit(input logic g, input logic x);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %0t bit %b, wanted %b", $time, g, x);
    end
  endtask
  task automatic chk_vec(input logic [1:0] g, input logic [1:0] x);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %0t dibit %b, wanted %b", $time, g, x);
    end
  endtask
  task automatic chk_num(input int g, input int lo, input int hi);
    tests_run++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("[ERR] %0t count %0d, wanted %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic nx(input int k);
    repeat (k) @(negedge clk);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return isol;
      1: return crs;
      2: return sd;
      3: return lp;
      default: return rx_dv;
    endcase
  endfunction
  task automatic wait_on(input int s, input logic v, input int lim, output int k);
    k = 0;
    while (pick(s) !== v && k < lim) begin
      nx(1);
      k++;
    end
  endtask
  task automatic note(input string s);
    $display("test %s ended, mismatches %0d", s, bad_count);
  endtask
  task automatic lb_try(input int lim);
    int w;
    fork
      mac.send(16'hB4E1);
      begin
        wait_on(4, 1'h1, lim + 5, w);
        chk_vec(rxdo, 2'h1);
      end
    join
    chk_num(w, 1, lim);
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog sized well past the longest sequence
  initial begin
    #(40000 * 100);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nx(12);
    chk_vec(esel, 2'h1);
    chk_bit(crs, 1'h0);
    nrst = 1'h1;
    ecfg = 2'h2;
    ewr = 1'h1;
    nx(1);
    ewr = 1'h0;
    chk_vec(esel, 2'h2);
    note("reset");
    nx(10);
    for (int j = 0; j < 8 + RX_LAT_CYC; j++) begin
      if (j >= RX_LAT_CYC) begin
        chk_vec(rxdo, rows[j-RX_LAT_CYC][2:1]);
        chk_bit(rx_dv, rows[j-RX_LAT_CYC][3]);
        chk_bit(rx_er, rows[j-RX_LAT_CYC][0]);
      end
      {rdv, rxd, rer} = (j < 8) ? rows[j] : 4'h0;
      nx(1);
    end
    note("receive rows");
    rdv = 1'h1;
    sos = 1'h1;
    nx(1);
    sos = 1'h0;
    wait_on(1, 1'h1, 10, n);
    chk_num(n, CRS_ON_CYC - 1, CRS_ON_CYC - 1);
    nx(6);
    eos = 1'h1;
    nx(1);
    eos = 1'h0;
    wait_on(1, 1'h0, 10, n);
    chk_num(n, CRS_OFF_CYC - 1, CRS_OFF_CYC - 1);
    rdv = 1'h0;
    cnt = 0;
    repeat (6) begin
      nx(1);
      cnt += int'(crs === 1'h1);
    end
    chk_num(cnt, 1, 3);
    note("carrier");
    fork
      mac.send(16'hB4E1);
      repeat (10) begin
        @(posedge clk);
        e = {tx_en, txd};
        @(negedge clk);
        chk_vec(ltxd, e[1:0]);
        chk_bit(ltx_en, e[2]);
      end
    join
    repeat (4) begin
      rmii = ~rmii;
      e[0] = mclk;
      nx(1);
      chk_bit(mclk, ~e[0]);
    end
    note("transmit and clock");
    speed = 1'h0;
    wait_on(3, 1'h1, 100, n);
    nx(1);
    chk_bit(lp, 1'h0);
    wait_on(3, 1'h1, 100, n);
    chk_num(n, NLP_CYC - 1, NLP_CYC - 1);
    note("idle pulses");
    speed = 1'h1;
    energy = 1'h1;
    nx(5);
    energy = 1'h0;
    cnt = 0;
    repeat (30) begin
      nx(1);
      cnt += int'(sd === 1'h1);
    end
    chk_num(cnt, 0, 0);
    energy = 1'h1;
    wait_on(2, 1'h1, 40, n);
    chk_num(n, 1, SD_ON);
    energy = 1'h0;
    wait_on(2, 1'h0, 4000, n);
    chk_num(n, 1, 3500);
    note("signal detect");
    lb = 1'h1;
    cnt = 0;
    fork
      mac.send(16'h3C5A);
      repeat (8) begin
        nx(1);
        cnt += int'(rx_dv === 1'h1);
      end
    join
    chk_num(cnt, 0, 0);
    nx(LB_DEAD);
    lb_try(3);
    speed = 1'h0;
    nx(30);
    lb_try(21);
    lb = 1'h0;
    note("loopback");
    iso = 1'h1;
    nx(1);
    chk_bit(isol, 1'h1);
    fork
      mac.send(16'hFFFF);
      repeat (9) begin
        nx(1);
        chk_bit(ltx_en, 1'h0);
      end
    join
    iso = 1'h0;
    wait_on(0, 1'h0, 1100, n);
    chk_num(n, 1, ISO_EXIT_CYC);
    note("isolate");
    an = 1'h1;
    nrst = 1'h0;
    nx(2);
    nrst = 1'h1;
    wait_on(3, 1'h1, 10, n);
    got.push_back(0);
    for (int t = 1; t <= FLP_PER; t++) begin
      nx(1);
      if (lp === 1'h1) got.push_back(t);
    end
    for (int k = 0; k <= FLP_SLOTS; k++) begin
      want.push_back(k * CLK_GAP);
      if (k < FLP_SLOTS && flp[k] === 1'h1) want.push_back(k * CLK_GAP + DATA_GAP);
    end
    want.push_back(FLP_PER);
    chk_num(got.size(), want.size(), want.size());
    foreach (want[i]) chk_num(i < got.size() ? got[i] : -1, want[i], want[i]);
    note("burst");
    stop_test();
  end
endmodule
